/* File: logic/gnpc_top.v */
// Gigabit next page receive and gigabit control registers behind AXI4-Lite.
// Assumes the negotiation logic shares clk_i; the strap pin is asynchronous.
//
// Local design decision: register access over AXI4-Lite.
`include "gnpc_defines.vh"
`default_nettype none

// Overview of operation
// - Received toggle bit reads inverse of toggle in last received code word; resets 0.
// - Stored toggle always tracks inverse of previously exchanged toggle, keeping sync.
// - Code bits 10:0 are read-only; message page flag selects their meaning.
// - Received code field reads all zeros after reset.
// - Received next page register loads the partner's page during negotiation.
// - Control bits 15:13 select test mode; reset value zero is normal operation.
// - Control bit 12 enables manual master/slave configuration; resets to zero.
// - Control bit 11 forces master when one, slave when zero, if manual.
// - Control bit 10 advertises repeater or DTE; strap sets reset value while auto-negotiation is enabled, else zero.
module gnpc_top
#(
    parameter ADDR_W = 12
)
(
    input  wire              clk_i,
    input  wire              sys_rst_i,
    // AXI4-Lite write address
    input  wire [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire              s_axi_awvalid_i,
    output wire              s_axi_awready_o,
    // AXI4-Lite write data
    input  wire [31:0]       s_axi_wdata_i,
    input  wire [3:0]        s_axi_wstrb_i,
    input  wire              s_axi_wvalid_i,
    output wire              s_axi_wready_o,
    // AXI4-Lite write response
    output wire [1:0]        s_axi_bresp_o,
    output wire              s_axi_bvalid_o,
    input  wire              s_axi_bready_i,
    // AXI4-Lite read address
    input  wire [ADDR_W-1:0] s_axi_araddr_i,
    input  wire              s_axi_arvalid_i,
    output wire              s_axi_arready_o,
    // AXI4-Lite read data
    output wire [31:0]       s_axi_rdata_o,
    output wire [1:0]        s_axi_rresp_o,
    output wire              s_axi_rvalid_o,
    input  wire              s_axi_rready_i,
    // Negotiation side
    input  wire              aneg_enable_i,
    input  wire              np_load_i,
    input  wire [15:0]       np_page_i,
    input  wire              repeater_strap_i,
    // Control and received next page outputs
    output wire [2:0]        test_mode_o,
    output wire              ms_manual_en_o,
    output wire              ms_manual_val_o,
    output wire              ms_force_master_o,
    output wire              ms_force_slave_o,
    output wire              repeater_adv_o,
    output wire              received_toggle_bit_o,
    output wire              message_page_flag_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg               awready_r;
    reg               wready_r;
    reg               bvalid_r;
    reg  [1:0]        bresp_r;
    reg               arready_r;
    reg               rvalid_r;
    reg  [1:0]        rresp_r;
    reg  [31:0]       rdata_r;
    reg               aw_full_r;
    reg               w_full_r;
    reg               ar_full_r;
    reg  [ADDR_W-1:0] aw_addr_r;
    reg  [ADDR_W-1:0] ar_addr_r;
    reg  [31:0]       wdata_r;
    reg  [3:0]        wstrb_r;

    reg  [2:0]        test_mode_r;
    reg               ms_en_r;
    reg               ms_val_r;
    reg               rep_r;
    reg               strap_pend_r;
    reg               force_master_r;
    reg               force_slave_r;

    reg  [31:0]       rdata_nxt;
    reg  [1:0]        rresp_nxt;
    reg  [1:0]        bresp_nxt;

    wire              wr_go;
    wire              rd_go;
    wire              strap_sync;
    wire [15:0]       np_page;
    wire              msg_flag;
    wire [15:0]       ctrl_word;

    localparam [ADDR_W-3:0] CTRL_IDX = {{(ADDR_W-10){1'b0}}, `GNPC_CTRL_IDX};
    localparam [ADDR_W-3:0] NPRX_IDX = {{(ADDR_W-10){1'b0}}, `GNPC_NP_RX_IDX};

    // ------------------------------------------------------------------
    // Helper instances
    // ------------------------------------------------------------------
    gnpc_sync2 u_strap_sync
    (
        .clk_i   (clk_i),
        .async_i (repeater_strap_i),
        .sync_o  (strap_sync)
    );

    gnpc_np_rx u_np_rx
    (
        .clk_i               (clk_i),
        .sys_rst_i           (sys_rst_i),
        .page_load_i         (np_load_i),
        .page_i              (np_page_i),
        .page_o              (np_page),
        .message_page_flag_o (msg_flag)
    );

    // ------------------------------------------------------------------
    // Write channels
    // ------------------------------------------------------------------
    // Address and data are taken independently; the write happens once
    // both are held and no response is pending.
    assign wr_go = aw_full_r & w_full_r & ~bvalid_r;

    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `GNPC_RESP_OKAY;
            aw_addr_r <= {ADDR_W{1'b0}};
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid_i && awready_r)
            begin
                aw_addr_r <= s_axi_awaddr_i;
                aw_full_r <= 1'b1;
                awready_r <= 1'b0;
            end
            else if (!aw_full_r && !bvalid_r)
            begin
                awready_r <= 1'b1;
            end
            if (s_axi_wvalid_i && wready_r)
            begin
                wdata_r  <= s_axi_wdata_i;
                wstrb_r  <= s_axi_wstrb_i;
                w_full_r <= 1'b1;
                wready_r <= 1'b0;
            end
            else if (!w_full_r && !bvalid_r)
            begin
                wready_r <= 1'b1;
            end
            if (wr_go)
            begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= bresp_nxt;
            end
            else if (bvalid_r && s_axi_bready_i)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Writes to the read-only page register answer OKAY and change nothing.
    always @*
    begin
        bresp_nxt = `GNPC_RESP_SLVERR;
        if (aw_addr_r[ADDR_W-1:2] == CTRL_IDX)
            bresp_nxt = `GNPC_RESP_OKAY;
        else if (aw_addr_r[ADDR_W-1:2] == NPRX_IDX)
            bresp_nxt = `GNPC_RESP_OKAY;
    end

    // ------------------------------------------------------------------
    // Gigabit control register
    // ------------------------------------------------------------------
    // The strap is caught in the first cycle after reset release, and
    // only while auto-negotiation is enabled.
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            test_mode_r  <= `GNPC_TM_RST;
            ms_en_r      <= `GNPC_MSEN_RST;
            ms_val_r     <= `GNPC_MSVAL_RST;
            rep_r        <= `GNPC_REP_RST;
            strap_pend_r <= 1'b1;
        end
        else
        begin
            if (strap_pend_r)
            begin
                strap_pend_r <= 1'b0;
                if (aneg_enable_i)
                    rep_r <= strap_sync;
            end
            if (wr_go && (aw_addr_r[ADDR_W-1:2] == CTRL_IDX) && wstrb_r[1])
            begin
                test_mode_r <= wdata_r[`GNPC_TM_HI:`GNPC_TM_LO];
                ms_en_r     <= wdata_r[`GNPC_MSEN_BIT];
                ms_val_r    <= wdata_r[`GNPC_MSVAL_BIT];
                rep_r       <= wdata_r[`GNPC_REP_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Master/slave role forcing
    // ------------------------------------------------------------------
    // The forced role follows the stored bits one cycle later.
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            force_master_r <= 1'b0;
            force_slave_r  <= 1'b0;
        end
        else
        begin
            force_master_r <= ms_en_r & ms_val_r;
            force_slave_r  <= ms_en_r & ~ms_val_r;
        end
    end

    assign ctrl_word = {test_mode_r, ms_en_r, ms_val_r, rep_r, 10'h000};

    // ------------------------------------------------------------------
    // Read channels
    // ------------------------------------------------------------------
    assign rd_go = ar_full_r & ~rvalid_r;

    always @*
    begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = `GNPC_RESP_SLVERR;
        if (ar_addr_r[ADDR_W-1:2] == CTRL_IDX)
        begin
            rdata_nxt = {16'h0000, ctrl_word};
            rresp_nxt = `GNPC_RESP_OKAY;
        end
        else if (ar_addr_r[ADDR_W-1:2] == NPRX_IDX)
        begin
            rdata_nxt = {16'h0000, np_page};
            rresp_nxt = `GNPC_RESP_OKAY;
        end
    end

    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            arready_r <= 1'b0;
            ar_full_r <= 1'b0;
            ar_addr_r <= {ADDR_W{1'b0}};
            rvalid_r  <= 1'b0;
            rresp_r   <= `GNPC_RESP_OKAY;
            rdata_r   <= 32'h00000000;
        end
        else
        begin
            if (s_axi_arvalid_i && arready_r)
            begin
                ar_addr_r <= s_axi_araddr_i;
                ar_full_r <= 1'b1;
                arready_r <= 1'b0;
            end
            else if (!ar_full_r && !rvalid_r)
            begin
                arready_r <= 1'b1;
            end
            if (rd_go)
            begin
                ar_full_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= rdata_nxt;
                rresp_r   <= rresp_nxt;
            end
            else if (rvalid_r && s_axi_rready_i)
            begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready_o       = awready_r;
    assign s_axi_wready_o        = wready_r;
    assign s_axi_bvalid_o        = bvalid_r;
    assign s_axi_bresp_o         = bresp_r;
    assign s_axi_arready_o       = arready_r;
    assign s_axi_rvalid_o        = rvalid_r;
    assign s_axi_rresp_o         = rresp_r;
    assign s_axi_rdata_o         = rdata_r;
    assign test_mode_o           = test_mode_r;
    assign ms_manual_en_o        = ms_en_r;
    assign ms_manual_val_o       = ms_val_r;
    assign ms_force_master_o     = force_master_r;
    assign ms_force_slave_o      = force_slave_r;
    assign repeater_adv_o        = rep_r;
    assign received_toggle_bit_o = np_page[`GNPC_NP_TOG_BIT];
    assign message_page_flag_o   = msg_flag;

endmodule

`default_nettype wire

/* File: logic/gnpc_defines.vh */
// Constants for the gigabit next page and control register bank.
// Assumes it is included by bare name from the design files of this block.
`ifndef GNPC_DEFINES_VH
`define GNPC_DEFINES_VH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define GNPC_NP_RX_IDX      8'h08
`define GNPC_CTRL_IDX       8'h09
`define GNPC_NP_RX_ADDR     {`GNPC_NP_RX_IDX, 2'b00}
`define GNPC_CTRL_ADDR      {`GNPC_CTRL_IDX, 2'b00}

// ----------------------------------------------------------------------
// Received next page fields
// ----------------------------------------------------------------------
`define GNPC_NP_MSG_BIT     13
`define GNPC_NP_TOG_BIT     11
`define GNPC_NP_CODE_HI     10
`define GNPC_NP_CODE_LO     0
`define GNPC_NP_RST         16'h0000
`define GNPC_CODE_RST       11'h000

// ----------------------------------------------------------------------
// Gigabit control fields and reset values
// ----------------------------------------------------------------------
`define GNPC_TM_HI          15
`define GNPC_TM_LO          13
`define GNPC_MSEN_BIT       12
`define GNPC_MSVAL_BIT      11
`define GNPC_REP_BIT        10
`define GNPC_TM_RST         3'h0
`define GNPC_MSEN_RST       1'b0
`define GNPC_MSVAL_RST      1'b0
`define GNPC_REP_RST        1'b0

// ----------------------------------------------------------------------
// Test mode codes
// ----------------------------------------------------------------------
`define GNPC_TM_NORMAL      3'h0
`define GNPC_TM_MODE1       3'h1
`define GNPC_TM_MODE2       3'h2
`define GNPC_TM_MODE3       3'h3
`define GNPC_TM_MODE4       3'h4

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define GNPC_RESP_OKAY      2'h0
`define GNPC_RESP_SLVERR    2'h2

`endif

/* File: logic/gnpc_sync2.v */
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes the level changes slowly compared with the clock.
`default_nettype none

module gnpc_sync2
(
    input  wire clk_i,
    input  wire async_i,
    output wire sync_o
);

    reg stage1_r;
    reg stage2_r;

    // The stages carry no reset so the strap is valid right at release.
    always @(posedge clk_i)
    begin
        stage1_r <= async_i;
        stage2_r <= stage1_r;
    end

    assign sync_o = stage2_r;

endmodule

`default_nettype wire

/* File: logic/gnpc_np_rx.v */
// Holds the next page received from the link partner.
// Assumes the negotiation logic on the same clock pulses page_load_i once per page.
`include "gnpc_defines.vh"
`default_nettype none

module gnpc_np_rx
(
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire        page_load_i,
    input  wire [15:0] page_i,
    output wire [15:0] page_o,
    output wire        message_page_flag_o
);

    reg [15:0] page_r;

    // ------------------------------------------------------------------
    // Page capture
    // ------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            page_r <= `GNPC_NP_RST;
        end
        else if (page_load_i)
        begin
            page_r <= page_i;
            page_r[`GNPC_NP_TOG_BIT] <= ~page_i[`GNPC_NP_TOG_BIT];
        end
    end

    assign page_o              = page_r;
    assign message_page_flag_o = page_r[`GNPC_NP_MSG_BIT];

endmodule

`default_nettype wire

/* File: dv/gnpc_asserts.sv */
// Port checks for the gigabit next page and control register bank.
// Assumes one clock domain; it is bound to gnpc_top from the bench.
`default_nettype none

module gnpc_asserts
(
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        np_load_i,
    input wire logic [15:0] np_page_i,
    input wire logic        aneg_enable_i,
    input wire logic        repeater_strap_i,
    input wire logic        s_axi_bvalid_o,
    input wire logic [2:0]  test_mode_o,
    input wire logic        ms_manual_en_o,
    input wire logic        ms_manual_val_o,
    input wire logic        ms_force_master_o,
    input wire logic        ms_force_slave_o,
    input wire logic        repeater_adv_o,
    input wire logic        received_toggle_bit_o,
    input wire logic        message_page_flag_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_tog; np_load_i |=> received_toggle_bit_o == !$past(np_page_i[11]); endproperty
    a_tog: assert property (p_tog)
        else $error("toggle bit not inverse of loaded toggle");
    property p_msg; np_load_i |=> message_page_flag_o == $past(np_page_i[13]); endproperty
    a_msg: assert property (p_msg)
        else $error("message page flag not loaded");
    property p_pg_hold; !np_load_i |=> $stable({received_toggle_bit_o, message_page_flag_o});
    endproperty
    a_pg_hold: assert property (p_pg_hold)
        else $error("page fields changed without a load");
    property p_rst; $fell(sys_rst_i) |-> !(|{test_mode_o, ms_manual_en_o, ms_manual_val_o,
        received_toggle_bit_o, message_page_flag_o}); endproperty
    a_rst: assert property (p_rst)
        else $error("output not zero after reset");
    property p_fm; ms_force_master_o == $past(ms_manual_en_o && ms_manual_val_o); endproperty
    a_fm: assert property (p_fm)
        else $error("force master wrong");
    property p_fs; ms_force_slave_o == $past(ms_manual_en_o && !ms_manual_val_o); endproperty
    a_fs: assert property (p_fs)
        else $error("force slave wrong");
    property p_ctl; !$rose(s_axi_bvalid_o) |->
        $stable({test_mode_o, ms_manual_en_o, ms_manual_val_o}); endproperty
    a_ctl: assert property (p_ctl)
        else $error("control changed without a write");
    property p_rep_hold; !$rose(s_axi_bvalid_o) && !$past(sys_rst_i, 2) |->
        $stable(repeater_adv_o); endproperty
    a_rep_hold: assert property (p_rep_hold)
        else $error("repeater bit changed without a write");
    property p_strap; $fell(sys_rst_i) |->
        ##2 repeater_adv_o == (aneg_enable_i && repeater_strap_i); endproperty
    a_strap: assert property (p_strap)
        else $error("repeater bit not taken from strap");
endmodule

`default_nettype wire

/* File: dv/gnpc_tb_top.sv */
// Self-checking bench for the gigabit next page and control register bank.
// Assumes the design files are compiled first; AXI4-Lite master lives here.
`default_nettype none

module gnpc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        aneg = 1'b1, strap = 1'b1, np_load = 1'b0;
    logic [15:0] np_page = 16'h0000;
    logic [15:0] pg [6] = '{16'hA5A5, 16'h2800, 16'h07FF, 16'hD7FF, 16'h0800, 16'hFFFF};
    wire         awready, wready, bvalid, arready, rvalid, ms_en, ms_val, f_m, f_s, rep, tog, pgf;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [2:0]  tm;
    int          bad_count = 0;
    int          checks = 0;

    gnpc_top dut_u
    (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .aneg_enable_i(aneg),
        .np_load_i(np_load), .np_page_i(np_page), .repeater_strap_i(strap),
        .test_mode_o(tm), .ms_manual_en_o(ms_en), .ms_manual_val_o(ms_val),
        .ms_force_master_o(f_m), .ms_force_slave_o(f_s), .repeater_adv_o(rep),
        .received_toggle_bit_o(tog), .message_page_flag_o(pgf)
    );

    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Each bus wait is bounded; running out ends the run as a mismatch.
    task automatic tick(inout int n);
        n++;
        if (n > 200)
        begin
            bad_count++;
            $display("BAD bus_wait expected answer seen none");
            stop_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int   n;
        logic ta, tw, tb;
        // One edge passes so a back-to-back call never reassigns a strobe in one step.
        @(posedge clk_i);
        n = 0;
        tb = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb)
        begin
            @(negedge clk_i);
            tick(n);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            if (tb)
                chk("bresp", {30'h0, er}, {30'h0, bresp});
            @(posedge clk_i);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int   n;
        logic ta, tr;
        @(posedge clk_i);
        n = 0;
        tr = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr)
        begin
            @(negedge clk_i);
            tick(n);
            ta = arvalid && arready;
            tr = rvalid && rready;
            if (tr)
                chk($sformatf("rdata %h", a), ed, rdata);
            if (tr)
                chk("rresp", {30'h0, er}, {30'h0, rresp});
            @(posedge clk_i);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end
    endtask

    task automatic reset_dut(input logic a, input logic s);
        sys_rst_i <= 1'b1;
        aneg <= a;
        strap <= s;
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // ----------------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------------
    initial
    begin
        reset_dut(1'b1, 1'b1);
        rd(12'h024, 32'h0000_0400, 2'h0);
        rd(12'h020, 32'h0, 2'h0);
        $display("Test reset values done");
        for (int i = 0; i < 5; i++)
        begin
            wr(12'h024, {16'h0, i[2:0], 3'h0, 10'h3FF}, 4'h3, 2'h0);
            rd(12'h024, {16'h0, i[2:0], 13'h0}, 2'h0);
            chk("test_mode", {29'h0, i[2:0]}, {29'h0, tm});
        end
        $display("Test modes done");
        for (int j = 0; j < 4; j++)
        begin
            wr(12'h024, {16'h0, 3'h0, j[1:0], j[0], 10'h0}, 4'h2, 2'h0);
            @(negedge clk_i);
            chk("force_master", {31'h0, j[1] & j[0]}, {31'h0, f_m});
            chk("force_slave", {31'h0, j[1] & ~j[0]}, {31'h0, f_s});
            chk("ctrl_pins", {29'h0, j[1:0], j[0]}, {29'h0, ms_en, ms_val, rep});
            @(posedge clk_i);
        end
        wr(12'h024, 32'h0000_E000, 4'h1, 2'h0);
        rd(12'h024, 32'h0000_1C00, 2'h0);
        $display("Test master slave done");
        for (int k = 0; k < 6; k += 2)
        begin
            np_load <= 1'b1;
            np_page <= pg[k];
            @(posedge clk_i);
            np_page <= pg[k + 1];
            @(posedge clk_i);
            np_load <= 1'b0;
            np_page <= ~pg[k + 1];
            @(negedge clk_i);
            chk("toggle", {31'h0, ~pg[k + 1][11]}, {31'h0, tog});
            chk("msg_flag", {31'h0, pg[k + 1][13]}, {31'h0, pgf});
            @(posedge clk_i);
            rd(12'h020, {16'h0, pg[k + 1] ^ 16'h0800}, 2'h0);
        end
        wr(12'h020, 32'h0000_FFFF, 4'hF, 2'h0);
        rd(12'h020, 32'h0000_F7FF, 2'h0);
        $display("Test next page done");
        wr(12'h028, 32'h0000_FFFF, 4'hF, 2'h2);
        rd(12'h028, 32'h0, 2'h2);
        rd(12'h024, 32'h0000_1C00, 2'h0);
        $display("Test unmapped done");
        reset_dut(1'b0, 1'b1);
        rd(12'h024, 32'h0, 2'h0);
        rd(12'h020, 32'h0, 2'h0);
        $display("Test second reset done");
        reset_dut(1'b1, 1'b0);
        rd(12'h024, 32'h0, 2'h0);
        $display("Test strap low done");
        stop_test();
    end
endmodule

bind gnpc_top gnpc_asserts chk_u
(
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .np_load_i(np_load_i), .np_page_i(np_page_i),
    .aneg_enable_i(aneg_enable_i), .repeater_strap_i(repeater_strap_i),
    .s_axi_bvalid_o(s_axi_bvalid_o), .test_mode_o(test_mode_o),
    .ms_manual_en_o(ms_manual_en_o), .ms_manual_val_o(ms_manual_val_o),
    .ms_force_master_o(ms_force_master_o), .ms_force_slave_o(ms_force_slave_o),
    .repeater_adv_o(repeater_adv_o), .received_toggle_bit_o(received_toggle_bit_o),
    .message_page_flag_o(message_page_flag_o)
);

`default_nettype wire
